// File: rtl/clkdist_pkg.sv
/*
  Package for the clock distribution block: mode codes, divider and delay
  limits, field widths and the carrier structs.
  Assumes the user keeps every field at a valid encoding.
*/
package clkdist_pkg;
  localparam int NUM_CH = 6;                 // Divider/delay channels
  localparam int DIV_W = 11;                 // Divide ratio width
  localparam logic [10:0] DIV_MIN = 11'h001; // Smallest ratio
  localparam logic [10:0] DIV_MAX = 11'h415; // 1045
  localparam logic [10:0] EXT_THRESH = 11'h01A; // 26 and up is extended
  localparam int DLY_W = 10;                 // Coarse delay, half-cycle units
  localparam logic [9:0] NORM_DLY_MIN = 10'h009; // 4.5 cycles
  localparam logic [9:0] NORM_DLY_MAX = 10'h018; // 12 cycles
  localparam logic [9:0] EXT_DLY_MIN = 10'h019;  // 12.5 cycles
  localparam logic [10:0] EXT_DLY_MAX = 11'h414; // 522 cycles, needs 11 bits
  localparam int FINE_W = 5;                 // Fine delay step count
  localparam logic [4:0] FINE_MAX = 5'h13;   // 19 steps of 25 ps = 475 ps
  localparam int FINE_STEP_PS = 25;          // Nominal step
  localparam int FINE_OFFSET_PS = 500;       // Added when enabled
  localparam int VCODIV_W = 4;
  localparam logic [3:0] VCODIV_MIN = 4'h2;
  localparam logic [3:0] VCODIV_MAX = 4'h8;
  localparam int MODE_W = 5;                 // Device mode field width
  localparam int MODE_LSB = 27;              // Field position in its word
  localparam logic [4:0] MODE_DUAL_INT = 5'h00;
  localparam logic [4:0] MODE_DUAL_INT_ZD = 5'h02;
  localparam logic [4:0] MODE_DUAL_EXT = 5'h03;
  localparam logic [4:0] MODE_DUAL_EXT_ZD = 5'h05;
  localparam logic [4:0] MODE_SINGLE_INT = 5'h06;
  localparam logic [4:0] MODE_SINGLE_INT_ZD = 5'h08;
  localparam logic [4:0] MODE_SINGLE_EXT = 5'h0B;
  localparam logic [4:0] MODE_DIST_ONLY = 5'h10;
  localparam logic [10:0] DEF_NOMINAL_DIV = 11'h019; // Default-output ratio, arbitrary
  localparam int DEF_NOMINAL_CH = 4;         // Channel running from reset
  localparam int DEF_OSC_CH = 3;             // Channel fed by oscillator at reset
  localparam logic [2:0] FB_SRC_EXT = 3'h6;  // Feedback select: external input
  localparam int NUM_REF = 3;                // Reference inputs

  typedef struct packed {
    logic [10:0] div;        // Divide ratio
    logic [9:0] coarse;      // Coarse delay, half-cycle units
    logic half_step;         // Half-step delay bit
    logic fine_en;           // Fine delay enable
    logic [4:0] fine;        // Fine delay steps
    logic osc_src;           // Feed from oscillator (channels 3 and 4 only)
    logic powerdown;         // Channel off
  } ch_cfg_t;

  typedef struct packed {
    logic ref_loop_on;       // Reference cleaning loop powered
    logic synth_loop_on;     // Frequency synthesis loop powered
    logic ext_vco;           // External VCO in use
    logic zero_delay;        // Zero-delay feedback in use
    logic dist_only;         // Distribution only
    logic valid;             // Mode code is a legal encoding
  } mode_dec_t;
endpackage

// File: rtl/clkdist_channel.sv
/*
  One divider/delay channel. Produces a 50% output from the distribution
  clock by a half-cycle phase counter, with coarse delay taken at sync.
  Assumes div and coarse are stable except across a sync.
*/
`timescale 1ns/1ns
module clkdist_channel (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire clkdist_pkg::ch_cfg_t cfg_i,
  input wire logic sync_i,
  input wire logic osc_clk_lvl_i,
  input wire logic active_i,
  output logic clk_o,
  output logic extended_o,
  output logic [9:0] fine_ps_idx_o
);
  // Period counter in half-cycle units: 2*div halves per period
  logic [11:0] phase_q, phase_d;
  logic [9:0] wait_q, wait_d;        // Coarse delay countdown after sync
  logic [9:0] applied_q, applied_d;  // Coarse value latched at sync
  logic hold_q, hold_d;              // Output held low during sync/delay
  logic out_q, out_d;
  logic [11:0] period;
  logic [9:0] step_dly;

  assign period = {cfg_i.div, 1'b0};
  // Half-step only honoured for ratios above one
  assign step_dly = (cfg_i.half_step && cfg_i.div > clkdist_pkg::DIV_MIN) ?
                    cfg_i.coarse : {cfg_i.coarse[9:1], 1'b0};
  assign extended_o = cfg_i.div >= clkdist_pkg::EXT_THRESH;

  // Next-state: hold, delay, then free divide
  always_comb begin
    phase_d = phase_q;
    wait_d = wait_q;
    applied_d = applied_q;
    hold_d = hold_q;
    out_d = out_q;
    if (sync_i) begin
      // New coarse value only takes effect here
      applied_d = step_dly;
      wait_d = step_dly;
      hold_d = 1'b1;
      phase_d = 12'h000;
      out_d = 1'b0;
    end else if (hold_q) begin
      if (wait_q <= 10'h001) begin
        // Channels with equal coarse delay leave hold aligned to the same rising edge
        hold_d = 1'b0;
        out_d = 1'b1;
        phase_d = 12'h001;
      end else begin
        wait_d = wait_q - 10'h001;
      end
    end else if (cfg_i.div <= clkdist_pkg::DIV_MIN) begin
      // Ratio one: output follows each half cycle
      out_d = ~out_q;
    end else begin
      // Toggle at half period; odd ratios land on a half-cycle boundary
      if (phase_q + 12'h001 >= period) begin
        phase_d = 12'h000;
        out_d = 1'b1;
      end else begin
        phase_d = phase_q + 12'h001;
        if (phase_q + 12'h001 == {1'b0, cfg_i.div}) begin
          out_d = 1'b0;
        end
      end
    end
  end

  // Registers only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_q <= 12'h000;
      wait_q <= 10'h000;
      applied_q <= 10'h000;
      hold_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      wait_q <= wait_d;
      applied_q <= applied_d;
      hold_q <= hold_d;
      out_q <= out_d;
    end
  end

  // Oscillator-sourced channels bypass divider; off channels stay low
  assign clk_o = !active_i ? 1'b0 : (cfg_i.osc_src ? osc_clk_lvl_i : out_q);
  // Fine delay in 25 ps units, with the fixed offset when enabled
  assign fine_ps_idx_o = cfg_i.fine_en ?
                         10'(cfg_i.fine) + 10'(clkdist_pkg::FINE_OFFSET_PS /
                         clkdist_pkg::FINE_STEP_PS) : 10'h000;
endmodule

// File: rtl/clkdist_top.sv
/*
  Clock distribution and mode control: mode decode, six channels,
  VCO post-divider, feedback selection, reference consumption, readback.
  Assumes all inputs synchronous to clk_i, the distribution clock.
*/
// Contract
// - Divide 1..1045 at 50% duty
// - Ratio 26 or more uses extended mode
// - Fine delay 25 ps steps, 500 ps offset
// - Coarse delay ranges per mode
// - Half-step bit halves coarse resolution for ratios above one
// - Coarse delay applies at sync only
// - Sync aligns all active divider outputs; oscillator-fed channels are unaffected
// - Fixed, absolute and relative dynamic delay
// - Feedback source: channel or external input
// - Zero-delay routes feedback to first loop
// - External VCO or feedback uses a reference
// - External VCO disables post-divider
// - Single loop powers down first loop
// - Decode five-bit device mode field
// - Six channels, two may use oscillator
// - Default outputs run before programming
// - Readback over serial port via status pin
// - Post-divider 2..8 at 50% duty
`timescale 1ns/1ns
module clkdist_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] device_mode_i,
  input wire logic programmed_i,
  input wire clkdist_pkg::ch_cfg_t [5:0] ch_cfg_i,
  input wire logic sync_i,
  input wire logic sync_enable_i,
  input wire logic sync_qualification_bit_i,
  input wire logic [1:0] dyn_delay_mode_i,
  input wire logic [9:0] rel_adjust_i,
  input wire logic rel_adjust_go_i,
  input wire logic oscillator_input_i,
  input wire logic crystal_mode_i,
  input wire logic vco_div_en_i,
  input wire logic [3:0] vco_div_i,
  input wire logic fb_mux_en_i,
  input wire logic [2:0] fb_select_i,
  input wire logic external_feedback_input_i,
  input wire logic readback_sel_i,
  input wire logic readback_data_i,
  output logic [5:0] ch_clk_o,
  output logic [5:0] ch_extended_o,
  output logic [59:0] fine_idx_o,
  output logic oscillator_buffer_output_o,
  output logic vco_post_div_clk_o,
  output logic feedback_clk_o,
  output clkdist_pkg::mode_dec_t mode_o,
  output logic [1:0] refs_available_o,
  output logic status_readback_o,
  output logic status_readback_oe_n_o
);
  clkdist_pkg::mode_dec_t mode_q, mode_d;         // Registered mode decode
  clkdist_pkg::ch_cfg_t [5:0] eff_cfg;            // Config after default/dyn
  logic [9:0] rel_q [6], rel_d [6];               // Relative delay accumulators
  logic [3:0] vdiv_cnt_q, vdiv_cnt_d;             // Post-divider phase
  logic vdiv_out_q, vdiv_out_d;
  logic fb_q, fb_d;                               // Registered feedback clock
  logic osc_buf_q, osc_buf_d;
  logic sync_ok;                                  // Qualified sync strobe
  logic [5:0] active;

  // Mode decode; illegal codes leave the previous decode out of use
  always_comb begin
    mode_d = '0;
    mode_d.valid = 1'b1;
    unique case (device_mode_i)
      clkdist_pkg::MODE_DUAL_INT: begin
        mode_d.ref_loop_on = 1'b1;
        mode_d.synth_loop_on = 1'b1;
      end
      clkdist_pkg::MODE_DUAL_INT_ZD: begin
        mode_d.ref_loop_on = 1'b1;
        mode_d.synth_loop_on = 1'b1;
        mode_d.zero_delay = 1'b1;
      end
      clkdist_pkg::MODE_DUAL_EXT: begin
        mode_d.ref_loop_on = 1'b1;
        mode_d.synth_loop_on = 1'b1;
        mode_d.ext_vco = 1'b1;
      end
      clkdist_pkg::MODE_DUAL_EXT_ZD: begin
        mode_d.ref_loop_on = 1'b1;
        mode_d.synth_loop_on = 1'b1;
        mode_d.ext_vco = 1'b1;
        mode_d.zero_delay = 1'b1;
      end
      clkdist_pkg::MODE_SINGLE_INT: begin
        mode_d.synth_loop_on = 1'b1;
      end
      clkdist_pkg::MODE_SINGLE_INT_ZD: begin
        mode_d.synth_loop_on = 1'b1;
        mode_d.zero_delay = 1'b1;
      end
      clkdist_pkg::MODE_SINGLE_EXT: begin
        mode_d.synth_loop_on = 1'b1;
        mode_d.ext_vco = 1'b1;
      end
      clkdist_pkg::MODE_DIST_ONLY: begin
        mode_d.dist_only = 1'b1;
      end
      default: begin
        // Host must not write these; flag them rather than guess
        mode_d.valid = 1'b0;
      end
    endcase
  end

  // Sync takes effect only when enabled; sync_qualification_bit_i is not used
  assign sync_ok = sync_i && sync_enable_i;

  // Relative dynamic delay accumulates offsets; absolute uses config
  always_comb begin
    for (int i = 0; i < clkdist_pkg::NUM_CH; i++) begin
      rel_d[i] = rel_q[i];
      if (sync_ok) begin
        rel_d[i] = ch_cfg_i[i].coarse;
      end else if (rel_adjust_go_i && dyn_delay_mode_i == 2'h2) begin
        rel_d[i] = rel_q[i] + rel_adjust_i;
      end
    end
  end

  // Effective channel configuration: defaults until programmed
  always_comb begin
    for (int i = 0; i < clkdist_pkg::NUM_CH; i++) begin
      eff_cfg[i] = ch_cfg_i[i];
      if (dyn_delay_mode_i == 2'h2) begin
        eff_cfg[i].coarse = rel_q[i];
      end
      if (!programmed_i) begin
        eff_cfg[i] = '0;
        eff_cfg[i].powerdown = 1'b1;
        if (i == clkdist_pkg::DEF_NOMINAL_CH) begin
          eff_cfg[i].powerdown = 1'b0;
          eff_cfg[i].div = clkdist_pkg::DEF_NOMINAL_DIV;
        end
        if (i == clkdist_pkg::DEF_OSC_CH) begin
          eff_cfg[i].powerdown = 1'b0;
          eff_cfg[i].osc_src = 1'b1;
        end
      end
      // Only two channels may take the oscillator directly
      if (i != clkdist_pkg::DEF_OSC_CH && i != clkdist_pkg::DEF_NOMINAL_CH) begin
        eff_cfg[i].osc_src = 1'b0;
      end
      active[i] = !eff_cfg[i].powerdown;
    end
  end

  // Six channels from the distribution clock
  for (genvar g = 0; g < clkdist_pkg::NUM_CH; g++) begin : g_ch
    clkdist_channel u_ch (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .cfg_i(eff_cfg[g]),
      .sync_i(sync_ok),
      .osc_clk_lvl_i(oscillator_input_i),
      .active_i(active[g]),
      .clk_o(ch_clk_o[g]),
      .extended_o(ch_extended_o[g]),
      .fine_ps_idx_o(fine_idx_o[g*10 +: 10])
    );
  end

  // Post-divider 2..8; counts half cycles, toggles at ratio boundaries
  always_comb begin
    vdiv_cnt_d = vdiv_cnt_q;
    vdiv_out_d = vdiv_out_q;
    if (mode_q.ext_vco || !vco_div_en_i) begin
      // External VCO leaves the post-divider idle
      vdiv_cnt_d = 4'h0;
      vdiv_out_d = 1'b0;
    end else if (vdiv_cnt_q + 4'h1 >= vco_div_i) begin
      vdiv_cnt_d = 4'h0;
      vdiv_out_d = ~vdiv_out_q;
    end else begin
      vdiv_cnt_d = vdiv_cnt_q + 4'h1;
    end
  end

  // Feedback mux and oscillator buffer
  always_comb begin
    fb_d = 1'b0;
    if (mode_q.zero_delay && fb_mux_en_i) begin
      if (fb_select_i == clkdist_pkg::FB_SRC_EXT) begin
        fb_d = external_feedback_input_i;
      end else if (fb_select_i < 3'h6) begin
        fb_d = ch_clk_o[fb_select_i];
      end
    end
    // Crystal mode gives no usable buffered copy at this pin
    osc_buf_d = crystal_mode_i ? 1'b0 : oscillator_input_i;
  end

  // All state registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q <= '0;
      vdiv_cnt_q <= 4'h0;
      vdiv_out_q <= 1'b0;
      fb_q <= 1'b0;
      osc_buf_q <= 1'b0;
      for (int i = 0; i < clkdist_pkg::NUM_CH; i++) begin
        rel_q[i] <= 10'h000;
      end
    end else begin
      mode_q <= mode_d;
      vdiv_cnt_q <= vdiv_cnt_d;
      vdiv_out_q <= vdiv_out_d;
      fb_q <= fb_d;
      osc_buf_q <= osc_buf_d;
      for (int i = 0; i < clkdist_pkg::NUM_CH; i++) begin
        rel_q[i] <= rel_d[i];
      end
    end
  end

  assign mode_o = mode_q;
  assign vco_post_div_clk_o = vdiv_out_q;
  assign feedback_clk_o = fb_q;
  assign oscillator_buffer_output_o = osc_buf_q;
  // One fewer reference when the shared input is taken
  assign refs_available_o = (mode_q.ext_vco || (mode_q.zero_delay && fb_mux_en_i &&
                            fb_select_i == clkdist_pkg::FB_SRC_EXT)) ?
                            2'h2 : 2'h3;
  // Status pin drives readback only once selected
  assign status_readback_o = readback_sel_i ? readback_data_i : 1'b0;
  assign status_readback_oe_n_o = !readback_sel_i;
endmodule

// File: test/clkdist_properties.sv
/* Port checker for clkdist_top.
   Assumes bind to clkdist_top with names matching its ports. */
`timescale 1ns/1ns
module clkdist_properties (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] device_mode_i,
  input wire logic programmed_i,
  input wire clkdist_pkg::ch_cfg_t [5:0] ch_cfg_i,
  input wire logic sync_i,
  input wire logic sync_enable_i,
  input wire logic oscillator_input_i,
  input wire logic fb_mux_en_i,
  input wire logic [2:0] fb_select_i,
  input wire logic external_feedback_input_i,
  input wire logic readback_sel_i,
  input wire logic readback_data_i,
  input wire logic [5:0] ch_clk_o,
  input wire logic [5:0] ch_extended_o,
  input wire logic oscillator_buffer_output_o,
  input wire logic feedback_clk_o,
  input wire clkdist_pkg::mode_dec_t mode_o,
  input wire logic [1:0] refs_available_o,
  input wire logic status_readback_o,
  input wire logic status_readback_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Legal device mode codes
  function automatic logic legal(input logic [4:0] m);
    return m inside {5'h00, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0B, 5'h10};
  endfunction
  // Sync accepted on this edge
  sequence s_sync;
    sync_i && sync_enable_i && programmed_i;
  endsequence
  // Channel 0 is a live divided clock
  sequence s_ch0_live;
    !ch_cfg_i[0].osc_src && !ch_cfg_i[0].powerdown;
  endsequence
  AST_SYNC_LOW: assert property (s_sync and s_ch0_live |=> !ch_clk_o[0])
    else $error("channel 0 not low after sync");
  AST_EXT0: assert property (programmed_i |-> ch_extended_o[0] == (ch_cfg_i[0].div >= 11'h01A))
    else $error("channel 0 extended flag wrong");
  AST_EXT5: assert property (programmed_i |-> ch_extended_o[5] == (ch_cfg_i[5].div >= 11'h01A))
    else $error("channel 5 extended flag wrong");
  AST_MODE_VALID: assert property (1'b1 |=> mode_o.valid == legal($past(device_mode_i)))
    else $error("mode valid flag wrong");
  AST_LOOP_OFF: assert property (1'b1 |=>
    mode_o.ref_loop_on == ($past(device_mode_i) inside {5'h00, 5'h02, 5'h03, 5'h05}))
    else $error("first loop power wrong");
  AST_REFS: assert property (mode_o.valid && $stable(device_mode_i) |->
    refs_available_o == ((mode_o.ext_vco || (mode_o.zero_delay && fb_mux_en_i &&
    fb_select_i == 3'h6)) ? 2'h2 : 2'h3))
    else $error("reference count wrong");
  AST_RB_DRIVE: assert property (readback_sel_i |->
    !status_readback_oe_n_o && status_readback_o == readback_data_i)
    else $error("readback pin not driven");
  AST_RB_IDLE: assert property (!readback_sel_i |-> status_readback_oe_n_o)
    else $error("readback pin driven while idle");
  AST_FB_EXT: assert property (mode_o.zero_delay && fb_mux_en_i && fb_select_i == 3'h6 |=>
    feedback_clk_o == $past(external_feedback_input_i))
    else $error("external feedback not routed");
  AST_BUF_OSC: assert property (!programmed_i |=>
    oscillator_buffer_output_o == $past(oscillator_input_i))
    else $error("oscillator buffer wrong");
endmodule
bind clkdist_top clkdist_properties i_props (.*);

// File: test/clk_sink.sv
/* Downstream clocked device: measures high and low run lengths of a tap.
   Assumes the tap only changes just after rising clk_i edges. */
`timescale 1ns/1ns
module clk_sink (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic tap_i,
  output logic [11:0] high_len_o,
  output logic [11:0] low_len_o
);
  logic [11:0] run_q; // Cycles at current level
  logic last_q; // Level seen last edge
  // First run after reset is partial, so callers wait two periods
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_q <= 12'h001;
      last_q <= 1'b0;
      high_len_o <= 12'h000;
      low_len_o <= 12'h000;
    end else if (tap_i != last_q) begin
      if (last_q) high_len_o <= run_q;
      else low_len_o <= run_q;
      run_q <= 12'h001;
      last_q <= tap_i;
    end else begin
      run_q <= run_q + 12'h001;
    end
  end
endmodule

// File: test/clock_distribution_divider_delay_tb_top.sv
/* Directed testbench for clkdist_top with clk_sink monitors.
   Assumes the bound checker; inputs change at falling edges. */
`timescale 1ns/1ns
module clock_distribution_divider_delay_tb_top;
  logic clk_i = 1'b0, reset_n_i = 1'b0, programmed_i = 1'b0, sync_i = 1'b0;
  logic sync_enable_i = 1'b0, sync_qualification_bit_i = 1'b0, rel_adjust_go_i = 1'b0;
  logic oscillator_input_i = 1'b0, crystal_mode_i = 1'b0, vco_div_en_i = 1'b0;
  logic fb_mux_en_i = 1'b0, external_feedback_input_i = 1'b0;
  logic readback_sel_i = 1'b0, readback_data_i = 1'b0;
  logic [4:0] device_mode_i = 5'h00;
  logic [1:0] dyn_delay_mode_i = 2'h0;
  logic [9:0] rel_adjust_i = 10'h000;
  logic [3:0] vco_div_i = 4'h2;
  logic [2:0] fb_select_i = 3'h0;
  clkdist_pkg::ch_cfg_t [5:0] ch_cfg_i = '0;
  logic [5:0] ch_clk_o, ch_extended_o;
  logic [59:0] fine_idx_o;
  logic oscillator_buffer_output_o, vco_post_div_clk_o, feedback_clk_o;
  logic status_readback_o, status_readback_oe_n_o;
  clkdist_pkg::mode_dec_t mode_o;
  logic [1:0] refs_available_o;
  logic [11:0] h0, l0, h4, l4, hv, lv; // Measured run lengths
  int failures = 0;
  int total_checks = 0;
  clkdist_top i_dut (.*);
  clk_sink i_sink0 (.clk_i, .reset_n_i, .tap_i(ch_clk_o[0]), .high_len_o(h0), .low_len_o(l0));
  clk_sink i_sink4 (.clk_i, .reset_n_i, .tap_i(ch_clk_o[4]), .high_len_o(h4), .low_len_o(l4));
  clk_sink i_sinkv (.clk_i, .reset_n_i, .tap_i(vco_post_div_clk_o), .high_len_o(hv),
    .low_len_o(lv));
  // 25 MHz clock
  initial forever #20 clk_i = ~clk_i;
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task results;
    if (failures == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Bounded wait for channel 0 level
  task wait_lvl(input logic v);
    for (int c = 0; c < 40 && ch_clk_o[0] !== v; c++) cyc(1);
  endtask
  task t_defaults;
    cyc(120);
    check("default high", clkdist_pkg::DEF_NOMINAL_DIV, h4);
    check("default low", clkdist_pkg::DEF_NOMINAL_DIV, l4);
    repeat (3) begin
      oscillator_input_i = ~oscillator_input_i;
      #1 check("osc channel", oscillator_input_i, ch_clk_o[3]);
      cyc(1);
      check("osc buffer", oscillator_input_i, oscillator_buffer_output_o);
    end
  endtask
  task t_modes;
    logic [4:0] code [8];
    logic [7:0] exp [8]; // Reference count, then decode
    code = '{5'h00, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0B, 5'h10};
    exp = '{8'hF1, 8'hF5, 8'hB9, 8'hBD, 8'hD1, 8'hD5, 8'h99, 8'hC3};
    for (int i = 0; i < 8; i++) begin
      device_mode_i = code[i];
      cyc(2);
      check("mode decode", exp[i][5:0], mode_o);
      check("references", exp[i][7:6], refs_available_o);
    end
    device_mode_i = 5'h01; // Refused code
    cyc(2);
    check("mode valid", 1'b0, mode_o.valid);
    device_mode_i = 5'h00;
  endtask
  task t_divider;
    logic [10:0] dv [6];
    dv = '{11'h001, 11'h002, 11'h003, 11'h019, 11'h01A, 11'h415};
    programmed_i = 1'b1;
    for (int i = 0; i < 6; i++) begin
      ch_cfg_i[0].div = dv[i];
      cyc(int'(dv[i]) * 4 + 6);
      check("high len", dv[i], h0);
      check("low len", dv[i], l0);
      check("extended", dv[i] >= 11'h01A, ch_extended_o[0]);
    end
  endtask
  task t_fine;
    ch_cfg_i[0].fine_en = 1'b1;
    for (int f = 0; f < 20; f += 19) begin
      ch_cfg_i[0].fine = f[4:0];
      #1 check("fine index", f + 20, fine_idx_o[9:0]);
    end
  endtask
  task t_sync;
    for (int i = 0; i < 3; i++) ch_cfg_i[i] = '{div: 11'(2 + 2 * i), coarse: 10'h00A, default: '0};
    sync_enable_i = 1'b1;
    sync_qualification_bit_i = 1'b1;
    for (int m = 0; m < 3; m++) begin
      dyn_delay_mode_i = m[1:0];
      cyc(20);
      sync_i = 1'b1;
      cyc(1);
      sync_i = 1'b0;
      wait_lvl(1);
      check("aligned", 3'h7, ch_clk_o[2:0]);
    end
    ch_cfg_i[0].div = 11'h008;
    ch_cfg_i[0].coarse = 10'h018; // Held back until a sync
    cyc(40);
    check("no sync delay", 8, h0);
    sync_enable_i = 1'b0; // Sync must be ignored now
    wait_lvl(0);
    wait_lvl(1);
    sync_i = 1'b1;
    cyc(1);
    sync_i = 1'b0;
    check("refused sync", 1'b1, ch_clk_o[0]);
  endtask
  task t_feedback;
    logic prev;
    device_mode_i = clkdist_pkg::MODE_DUAL_INT_ZD; // Feedback only routed in zero delay
    fb_mux_en_i = 1'b1;
    cyc(2);
    fb_select_i = clkdist_pkg::FB_SRC_EXT;
    repeat (3) begin
      external_feedback_input_i = ~external_feedback_input_i;
      cyc(1);
      check("ext feedback", external_feedback_input_i, feedback_clk_o);
    end
    fb_select_i = 3'h0;
    repeat (6) begin
      prev = ch_clk_o[0];
      cyc(1);
      check("chan feedback", prev, feedback_clk_o);
    end
    device_mode_i = clkdist_pkg::MODE_DUAL_INT;
    cyc(2);
  endtask
  task t_vcodiv;
    vco_div_en_i = 1'b1;
    for (int n = 2; n < 9; n += 3) begin
      vco_div_i = n[3:0];
      cyc(40);
      check("post div period", 2 * n, hv + lv);
    end
  endtask
  task t_readback;
    readback_sel_i = 1'b1;
    for (int b = 0; b < 2; b++) begin
      readback_data_i = b[0];
      #1 check("readback", {b[0], 1'b0}, {status_readback_o, status_readback_oe_n_o});
    end
    readback_sel_i = 1'b0;
    #1 check("readback idle", 1'b1, status_readback_oe_n_o);
  endtask
  // Holdover setup stays with the host; no holdover field reaches here
  // Main sequence
  initial begin
    cyc(3);
    reset_n_i = 1'b1;
    cyc(2);
    t_defaults;
    t_modes;
    t_divider;
    t_fine;
    t_sync;
    t_feedback;
    t_vcodiv;
    t_readback;
    results;
  end
  // Watchdog well above the expected run
  initial begin
    #2400000;
    failures++;
    results;
  end
endmodule
